// [core/ppm_pin_cell.sv]
// one pin driver: general i/o or alternate function, gated by operating mode
`timescale 1ns/1ps
module ppm_pin_cell import ppm_pkg::*; (
	input  wire logic      i_core_clk,
	input  wire logic      i_rst,
	input  wire ppm_mode_t i_mode,
	input  wire logic      i_sel_alt,
	input  wire logic      i_alt_out,
	input  wire logic      i_alt_oe,
	input  wire logic      i_dir,
	input  wire logic      i_data,
	input  wire logic      i_pu_ctl,
	output logic           o_out,
	output logic           o_oe,
	output logic           o_pu
);

	logic pu_want;

	assign pu_want = ~i_dir & i_pu_ctl; // R5

	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			// hi-z during reset
			o_out <= 1'b0; // R7
			o_oe  <= 1'b0; // R7
			o_pu  <= 1'b0; // R6
		end else begin
			case (i_mode)
				PPM_MODE_ACTIVE, PPM_MODE_SUBACTIVE: begin
					o_pu <= pu_want; // R5
					if (i_sel_alt) begin
						o_out <= i_alt_out; // R3 R4
						o_oe  <= i_alt_oe; // R1 R2 R16
					end else begin
						o_out <= i_data; // R19
						o_oe  <= i_dir; // R9 R17
					end
				end
				PPM_MODE_STANDBY: begin
					// hi-z, or driven high with pull-up on
					o_out <= 1'b1; // R7
					o_oe  <= pu_want; // R7
					o_pu  <= pu_want;
				end
				default: begin
					// sleep, subsleep, watch: hold previous state
					o_out <= o_out; // R7
					o_oe  <= o_oe;
					o_pu  <= o_pu;
				end
			endcase
		end
	end

endmodule

// [core/ppm_pkg.sv]
// package: register map, field layout, modes and carrier types of the port pin mux
package ppm_pkg;

	localparam int unsigned PPM_AW = 16;
	localparam int unsigned PPM_DW = 8;
	localparam int unsigned PPM_P2W = 3;

	// register byte addresses
	localparam logic [15:0] PPM_ADDR_P1_DATA = 16'hFFD4;
	localparam logic [15:0] PPM_ADDR_P1_DIR  = 16'hFFE4;
	localparam logic [15:0] PPM_ADDR_P1_PU   = 16'hFFED;
	localparam logic [15:0] PPM_ADDR_P1_FSEL = 16'hFFFC;
	localparam logic [15:0] PPM_ADDR_P2_DATA = 16'hFFD5;
	localparam logic [15:0] PPM_ADDR_P2_DIR  = 16'hFFE5;

	// reset values
	localparam logic [7:0] PPM_RST_P1_DATA = 8'h00;
	localparam logic [7:0] PPM_RST_P1_DIR  = 8'h00;
	localparam logic [7:0] PPM_RST_P1_PU   = 8'h00;
	localparam logic [7:0] PPM_RST_P1_FSEL = 8'h04;
	localparam logic [2:0] PPM_RST_P2_DATA = 3'h0;
	localparam logic [2:0] PPM_RST_P2_DIR  = 3'h0;

	// implemented bits of port 1, fixed read values
	localparam logic [7:0] PPM_P1_MASK     = 8'hF1;
	localparam logic [7:0] PPM_FSEL_FIXED1 = 8'h04;
	localparam logic [7:0] PPM_WO_READ     = 8'hFF;
	localparam logic [7:0] PPM_UNMAPPED    = 8'h00;

	// function select bit positions
	localparam int unsigned PPM_FSEL_INT3   = 7;
	localparam int unsigned PPM_FSEL_INT2   = 6;
	localparam int unsigned PPM_FSEL_INT1   = 5;
	localparam int unsigned PPM_FSEL_PWM    = 4;
	localparam int unsigned PPM_FSEL_CLKOUT = 0;

	// port 1 pins whose alternate function is an output
	localparam logic [7:0] PPM_P1_ALT_OE = 8'h11;

	typedef enum logic [2:0] {
		PPM_MODE_ACTIVE    = 3'b000,
		PPM_MODE_SUBACTIVE = 3'b001,
		PPM_MODE_SLEEP     = 3'b010,
		PPM_MODE_SUBSLEEP  = 3'b011,
		PPM_MODE_WATCH     = 3'b100,
		PPM_MODE_STANDBY   = 3'b101
	} ppm_mode_t;

	// serial function's claim on port 2 pins
	typedef struct packed {
		logic [2:0] sel;
		logic [2:0] out;
		logic [2:0] oe;
	} ppm_ser_t;

	// software register bus request
	typedef struct packed {
		logic [15:0] addr;
		logic [7:0]  wdata;
		logic        wr;
		logic        rd;
	} ppm_bus_t;

endpackage

// [core/ppm_port_io.sv]
// port 1 and port 2 registers, pin function muxing and pin-state control
//
// Functional notes
// R1: pin 7: input, output, or int3/trigger input
// R2: pins 6,5: gpio or interrupt n-4 input
// R3: pin 4 drives pwm when selected
// R4: pin 0 drives clock output when selected
// R5: pull-up only when input and enabled
// R6: pull-ups off after reset
// R7: reset/standby hi-z, sleep holds, active runs (standby drives pins high where pull-up is on)
// R8: port 2 has three data/direction bits
// R9: port 2 direction 1 output, 0 input
// R10: port 2 output pins read latch
// R11: port 2 input pins read pin level
// R12: port 2 data bits 7..3 read zero
// R13: reset clears port 2 data
// R14: reset clears port 2 direction
// R15: port 2 direction write-only, reads ones
// R16: serial function overrides port 2 settings
// R17: port 1 direction valid for gpio only
// R18: port 1 reads latch or pin level
// R19: general output drives data bit
`timescale 1ns/1ps
module ppm_port_io import ppm_pkg::*; (
	input  wire logic            i_core_clk,
	input  wire logic            i_rst,
	input  wire ppm_bus_t        i_bus,
	output logic       [7:0]     o_rdata,
	input  wire ppm_mode_t       i_mode,
	input  wire logic  [7:0]     i_p1_pin,
	output logic       [7:0]     o_p1_out,
	output logic       [7:0]     o_p1_oe,
	output logic       [7:0]     o_p1_pullup,
	input  wire logic            i_pwm,
	input  wire logic            i_clk_out,
	output logic       [3:1]     o_ext_int_lvl,
	output logic                 o_timer_trigger,
	input  wire logic  [2:0]     i_p2_pin,
	output logic       [2:0]     o_p2_out,
	output logic       [2:0]     o_p2_oe,
	input  wire ppm_ser_t        i_ser,
	output logic       [2:0]     o_ser_pin_in
);

	logic [7:0] p1_data_q;
	logic [7:0] p1_dir_q;
	logic [7:0] p1_pu_q;
	logic [7:0] p1_fsel_q;
	logic [2:0] p2_data_q;
	logic [2:0] p2_dir_q;
	logic [7:0] rdata_d;
	logic [7:0] p1_lvl;
	logic [2:0] p2_lvl;
	logic [7:0] p1_sel_alt;
	logic [7:0] p1_alt_out;

	// pin level sampling
	ppm_sync3 #(.W(8)) u_sync_p1 (
		.i_core_clk (i_core_clk),
		.i_rst      (i_rst),
		.i_pin      (i_p1_pin),
		.o_level    (p1_lvl)
	);

	ppm_sync3 #(.W(3)) u_sync_p2 (
		.i_core_clk (i_core_clk),
		.i_rst      (i_rst),
		.i_pin      (i_p2_pin),
		.o_level    (p2_lvl)
	);

	// port 1 registers
	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			p1_data_q <= PPM_RST_P1_DATA;
			p1_dir_q  <= PPM_RST_P1_DIR;
			p1_pu_q   <= PPM_RST_P1_PU; // R6
			p1_fsel_q <= PPM_RST_P1_FSEL;
		end else if (i_bus.wr) begin
			case (i_bus.addr)
				PPM_ADDR_P1_DATA: p1_data_q <= i_bus.wdata & PPM_P1_MASK;
				PPM_ADDR_P1_DIR:  p1_dir_q  <= i_bus.wdata & PPM_P1_MASK; // R17
				PPM_ADDR_P1_PU:   p1_pu_q   <= i_bus.wdata & PPM_P1_MASK;
				PPM_ADDR_P1_FSEL: begin
					p1_fsel_q <= (i_bus.wdata & PPM_P1_MASK) | PPM_FSEL_FIXED1;
				end
				default: begin
				end
			endcase
		end
	end

	// port 2 registers
	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			p2_data_q <= PPM_RST_P2_DATA; // R13
			p2_dir_q  <= PPM_RST_P2_DIR; // R14
		end else if (i_bus.wr) begin
			case (i_bus.addr)
				PPM_ADDR_P2_DATA: p2_data_q <= i_bus.wdata[2:0]; // R8 R12
				PPM_ADDR_P2_DIR:  p2_dir_q  <= i_bus.wdata[2:0]; // R9
				default: begin
				end
			endcase
		end
	end

	// read decode
	always_comb begin
		rdata_d = PPM_UNMAPPED;
		case (i_bus.addr)
			PPM_ADDR_P1_DATA: begin
				rdata_d = ((p1_dir_q & p1_data_q) | (~p1_dir_q & p1_lvl)) & PPM_P1_MASK; // R18
			end
			PPM_ADDR_P1_DIR:  rdata_d = PPM_WO_READ;
			PPM_ADDR_P1_PU:   rdata_d = p1_pu_q;
			PPM_ADDR_P1_FSEL: rdata_d = p1_fsel_q;
			PPM_ADDR_P2_DATA: begin
				rdata_d = {5'h00, (p2_dir_q & p2_data_q) | (~p2_dir_q & p2_lvl)}; // R10 R11 R12
			end
			PPM_ADDR_P2_DIR:  rdata_d = PPM_WO_READ; // R15
			default:          rdata_d = PPM_UNMAPPED;
		endcase
	end

	// read data valid only in the cycle after the strobe
	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			o_rdata <= 8'h00;
		end else if (i_bus.rd) begin
			o_rdata <= rdata_d;
		end else begin
			o_rdata <= 8'h00;
		end
	end

	// port 1 alternate function routing
	assign p1_sel_alt = p1_fsel_q & PPM_P1_MASK; // R1 R2 R3 R4
	always_comb begin
		p1_alt_out = 8'h00;
		p1_alt_out[PPM_FSEL_PWM] = i_pwm; // R3
		p1_alt_out[PPM_FSEL_CLKOUT] = i_clk_out; // R4
	end

	generate
		for (genvar g = 0; g < 8; g++) begin : g_p1
			ppm_pin_cell u_cell (
				.i_core_clk (i_core_clk),
				.i_rst      (i_rst),
				.i_mode     (i_mode),
				.i_sel_alt  (p1_sel_alt[g]),
				.i_alt_out  (p1_alt_out[g]),
				.i_alt_oe   (PPM_P1_ALT_OE[g]),
				.i_dir      (p1_dir_q[g]),
				.i_data     (p1_data_q[g]),
				.i_pu_ctl   (p1_pu_q[g]),
				.o_out      (o_p1_out[g]),
				.o_oe       (o_p1_oe[g]),
				.o_pu       (o_p1_pullup[g])
			);
		end
		for (genvar h = 0; h < 3; h++) begin : g_p2
			ppm_pin_cell u_cell (
				.i_core_clk (i_core_clk),
				.i_rst      (i_rst),
				.i_mode     (i_mode),
				.i_sel_alt  (i_ser.sel[h]), // R16
				.i_alt_out  (i_ser.out[h]),
				.i_alt_oe   (i_ser.oe[h]),
				.i_dir      (p2_dir_q[h]),
				.i_data     (p2_data_q[h]),
				.i_pu_ctl   (1'b0),
				.o_out      (o_p2_out[h]),
				.o_oe       (o_p2_oe[h]),
				.o_pu       ()
			);
		end
	endgenerate

	// pin levels handed to interrupt, timer and serial logic; idle high
	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			o_ext_int_lvl   <= 3'h7;
			o_timer_trigger <= 1'b1;
			o_ser_pin_in    <= 3'h7;
		end else begin
			o_ext_int_lvl[3] <= p1_fsel_q[PPM_FSEL_INT3] ? p1_lvl[7] : 1'b1; // R1
			o_ext_int_lvl[2] <= p1_fsel_q[PPM_FSEL_INT2] ? p1_lvl[6] : 1'b1; // R2
			o_ext_int_lvl[1] <= p1_fsel_q[PPM_FSEL_INT1] ? p1_lvl[5] : 1'b1; // R2
			o_timer_trigger  <= p1_fsel_q[PPM_FSEL_INT3] ? p1_lvl[7] : 1'b1; // R1
			o_ser_pin_in     <= (i_ser.sel & p2_lvl) | ~i_ser.sel; // R16
		end
	end

endmodule

// [core/ppm_sync3.sv]
// three-stage pin synchroniser that accepts a change once stages two and three agree
`timescale 1ns/1ps
module ppm_sync3 import ppm_pkg::*; #(
	parameter int unsigned W = 8
) (
	input  wire logic         i_core_clk,
	input  wire logic         i_rst,
	input  wire logic [W-1:0] i_pin,
	output logic      [W-1:0] o_level
);

	logic [W-1:0] s1_q;
	logic [W-1:0] s2_q;
	logic [W-1:0] s3_q;
	logic [W-1:0] agree;

	assign agree = ~(s2_q ^ s3_q);

	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			s1_q <= '0;
			s2_q <= '0;
			s3_q <= '0;
		end else begin
			s1_q <= i_pin;
			s2_q <= s1_q;
			s3_q <= s2_q;
		end
	end

	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			o_level <= '0;
		end else begin
			o_level <= (s3_q & agree) | (o_level & ~agree);
		end
	end

endmodule

// [tb/ppm_pin_model.sv]
// pin side: external drivers, pull-ups, floating pins
`timescale 1ns/1ps
module ppm_pin_model (
	input  wire logic       i_core_clk,
	input  wire logic [7:0] i_p1_out,
	input  wire logic [7:0] i_p1_oe,
	input  wire logic [7:0] i_p1_pu,
	input  wire logic [7:0] i_p1_ext,
	input  wire logic [7:0] i_p1_en,
	input  wire logic [2:0] i_p2_out,
	input  wire logic [2:0] i_p2_oe,
	input  wire logic [2:0] i_p2_ext,
	output logic      [7:0] o_p1_pin,
	output logic      [2:0] o_p2_pin
);
	logic tog = 1'b0;
	always @(posedge i_core_clk) tog <= ~tog;
	// undriven pin: pull-up high, else a changing level
	assign o_p1_pin = i_p1_oe & i_p1_out | ~i_p1_oe & i_p1_en & i_p1_ext
		| ~i_p1_oe & ~i_p1_en & (i_p1_pu | {8{tog}});
	assign o_p2_pin = i_p2_oe & i_p2_out | ~i_p2_oe & i_p2_ext;
endmodule

// [tb/ppm_port_io_assertions.sv]
// port pin mux assertions and bind
`timescale 1ns/1ps
module ppm_port_io_chk import ppm_pkg::*; (
	input wire logic       i_core_clk,
	input wire logic       i_rst,
	input wire ppm_bus_t   i_bus,
	input wire logic [7:0] o_rdata,
	input wire ppm_mode_t  i_mode,
	input wire logic [7:0] o_p1_out,
	input wire logic [7:0] o_p1_oe,
	input wire logic [7:0] o_p1_pullup,
	input wire logic [2:0] o_p2_out,
	input wire logic [2:0] o_p2_oe,
	input wire ppm_ser_t   i_ser
);
	default clocking @(posedge i_core_clk); endclocking
	default disable iff (i_rst);
	chk_pullup_off_out: assert property (
		$past(i_mode) inside {PPM_MODE_ACTIVE, PPM_MODE_SUBACTIVE}
		|-> (o_p1_oe & o_p1_pullup & 8'hE0) == 8'h00) else $error("pull-up on driven pin");
	chk_wo_read_ones: assert property (
		$past(i_bus.rd) && $past(i_bus.addr) == PPM_ADDR_P2_DIR |-> o_rdata == 8'hFF)
		else $error("direction read not ones");
	chk_p2_upper_zero: assert property (
		$past(i_bus.rd) && $past(i_bus.addr) == PPM_ADDR_P2_DATA |-> o_rdata[7:3] == 5'h00)
		else $error("port 2 upper bits set");
	chk_p1_gap_zero: assert property (
		$past(i_bus.rd) && $past(i_bus.addr) == PPM_ADDR_P1_DATA |-> o_rdata[3:1] == 3'h0)
		else $error("port 1 gap bits set");
	chk_hold_state: assert property (
		$past(i_mode) inside {PPM_MODE_SLEEP, PPM_MODE_SUBSLEEP, PPM_MODE_WATCH}
		|-> $stable(o_p1_oe) && $stable(o_p1_out) && $stable(o_p1_pullup) && $stable(o_p2_oe))
		else $error("pins moved while held");
	chk_standby_pins: assert property (
		$past(i_mode) == PPM_MODE_STANDBY |-> o_p1_oe == o_p1_pullup && o_p2_oe == 3'h0
		&& (o_p1_out | ~o_p1_oe) == 8'hFF) else $error("standby pin state wrong");
	chk_ser_oe_own: assert property (
		!$past(i_rst) && $past(i_mode) == PPM_MODE_ACTIVE
		|-> ((o_p2_oe ^ $past(i_ser.oe)) & $past(i_ser.sel)) == 3'h0) else $error("serial oe lost");
	chk_ser_out_own: assert property (
		!$past(i_rst) && $past(i_mode) == PPM_MODE_ACTIVE
		|-> ((o_p2_out ^ $past(i_ser.out)) & $past(i_ser.sel)) == 3'h0) else $error("serial out lost");
endmodule
bind ppm_port_io ppm_port_io_chk u_ppm_port_io_chk (.i_core_clk, .i_rst, .i_bus, .o_rdata,
	.i_mode, .o_p1_out, .o_p1_oe, .o_p1_pullup, .o_p2_out, .o_p2_oe, .i_ser);

// [tb/tb_ppm_port_io.sv]
// bench for the port pin mux: bus tasks, reference model, mode sweep
`timescale 1ns/1ps
module tb_ppm_port_io import ppm_pkg::*; ();
	logic        i_core_clk = 1'b0, i_rst = 1'b1, pwm = 1'b0, ck = 1'b0, trig;
	ppm_bus_t    bus = '0;
	ppm_mode_t   mode = PPM_MODE_ACTIVE;
	ppm_ser_t    ser = '0;
	logic [3:1]  eint;
	logic [7:0]  rdata, p1_out, p1_oe, p1_pu, p1_pin, en1, ext1 = '0;
	logic [7:0]  d1 = '0, r1 = '0, u1 = '0, f1 = 8'h04, eo1 = '0, eq1 = '0, ep1 = '0;
	logic [2:0]  p2_out, p2_oe, p2_pin, ser_in, d2 = '0, r2 = '0, eo2 = '0, eq2 = '0, ext2 = '0;
	logic [31:0] rnd;
	int          seed = 80365, cyc = 0, n_mismatch = 0, total_checks = 0;
	assign en1 = ~ep1;
	initial forever #10 i_core_clk = ~i_core_clk;
	ppm_port_io u_ppm_port_io (.i_core_clk(i_core_clk), .i_rst(i_rst), .i_bus(bus),
		.o_rdata(rdata), .i_mode(mode), .i_p1_pin(p1_pin), .o_p1_out(p1_out), .o_p1_oe(p1_oe),
		.o_p1_pullup(p1_pu), .i_pwm(pwm), .i_clk_out(ck), .o_ext_int_lvl(eint),
		.o_timer_trigger(trig), .i_p2_pin(p2_pin), .o_p2_out(p2_out), .o_p2_oe(p2_oe),
		.i_ser(ser), .o_ser_pin_in(ser_in));
	ppm_pin_model u_ppm_pin_model (.i_core_clk(i_core_clk), .i_p1_out(p1_out),
		.i_p1_oe(p1_oe), .i_p1_pu(p1_pu), .i_p1_ext(ext1), .i_p1_en(en1), .i_p2_out(p2_out),
		.i_p2_oe(p2_oe), .i_p2_ext(ext2), .o_p1_pin(p1_pin), .o_p2_pin(p2_pin));
	task automatic summarize();
		$display("checks %0d mismatches %0d", total_checks, n_mismatch);
		if (n_mismatch == 0 && total_checks > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	always @(posedge i_core_clk) begin
		cyc <= cyc + 1;
		if (cyc == 4000) begin
			n_mismatch++;
			summarize();
		end
	end
	task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
		total_checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		@(posedge i_core_clk);
		bus <= '{a, d, 1'b1, 1'b0};
		@(posedge i_core_clk);
		bus.wr <= 1'b0;
	endtask
	task automatic rd(input logic [15:0] a, input logic [7:0] e);
		@(posedge i_core_clk);
		bus <= '{a, 8'h00, 1'b0, 1'b1};
		@(posedge i_core_clk);
		bus.rd <= 1'b0;
		#1 cmp(rdata, e);
	endtask
	task automatic check_all();
		logic [7:0] l1, x;
		logic [2:0] l2;
		if (mode inside {PPM_MODE_ACTIVE, PPM_MODE_SUBACTIVE}) begin
			eo1 = (r1 & ~{f1[7:5], 5'h00} | {3'h0, f1[4], 3'h0, f1[0]}) & 8'hF1;
			eq1 = {d1[7:5], f1[4] ? pwm : d1[4], 3'h0, f1[0] ? ck : d1[0]};
			ep1 = ~r1 & u1;
			eo2 = ser.sel & ser.oe | ~ser.sel & r2;
			eq2 = ser.sel & ser.out | ~ser.sel & d2;
		end else if (mode == PPM_MODE_STANDBY) begin
			ep1 = ~r1 & u1;
			eo1 = ep1;
			eq1 = 8'hFF;
			eo2 = 3'h0;
		end
		l1 = eo1 & eq1 | ~eo1 & (ep1 | ext1);
		l2 = eo2 & eq2 | ~eo2 & ext2;
		x = {1'b0, ~f1[7:5] | l1[7:5], ~f1[7] | l1[7], ~ser.sel | l2};
		repeat (8) @(posedge i_core_clk);
		#1;
		cmp(p1_oe, eo1);
		cmp(p1_out & eo1, eq1 & eo1);
		cmp(p1_pu, ep1);
		cmp({2'h0, p2_oe, p2_out & eo2}, {2'h0, eo2, eq2 & eo2});
		cmp({1'b0, eint, trig, ser_in}, x);
		rd(PPM_ADDR_P1_DATA, (r1 & d1 | ~r1 & l1) & 8'hF1);
		rd(PPM_ADDR_P2_DATA, {5'h00, r2 & d2 | ~r2 & l2});
		rd(PPM_ADDR_P2_DIR, 8'hFF);
		rd(PPM_ADDR_P1_PU, u1);
		rd(PPM_ADDR_P1_FSEL, f1);
		rd(16'hFF00, 8'h00);
	endtask
	initial begin
		repeat (12) @(posedge i_core_clk);
		i_rst <= 1'b0;
		check_all();
		$display("reset values done");
		for (int i = 0; i < 36; i++) begin
			@(posedge i_core_clk);
			rnd = $random(seed);
			mode <= ppm_mode_t'(i % 6);
			{pwm, ck, ser, ext2, ext1} <= rnd[21:0];
			rnd = $random(seed);
			wr(PPM_ADDR_P1_DATA, rnd[7:0]);
			wr(PPM_ADDR_P1_DIR, rnd[15:8]);
			wr(PPM_ADDR_P1_PU, rnd[23:16]);
			wr(PPM_ADDR_P1_FSEL, rnd[31:24]);
			{f1, u1, r1, d1} = rnd & 32'hF1F1F1F1 | 32'h04000000;
			rnd = $random(seed);
			wr(PPM_ADDR_P2_DATA, rnd[7:0]);
			wr(PPM_ADDR_P2_DIR, rnd[15:8]);
			{r2, d2} = {rnd[10:8], rnd[2:0]};
			wr(16'hFF00, rnd[23:16]);
			check_all();
			$display("step %0d mode %0d done", i, i % 6);
		end
		@(posedge i_core_clk);
		i_rst <= 1'b1;
		mode  <= PPM_MODE_ACTIVE;
		repeat (2) @(posedge i_core_clk);
		i_rst <= 1'b0;
		{f1, u1, r1, d1} = 32'h04000000;
		{r2, d2} = 6'h00;
		check_all();
		$display("mid-run reset done");
		summarize();
	end
endmodule
